/* File: include/ff_pkg.sv */
package ff_pkg;

    // transform geometry
    localparam int N_PTS = 1024;
    localparam int ADDR_W = 10;
    localparam int IN_W = 13;
    localparam int INT_W = 16;
    localparam int TW_W = 16;
    localparam int TW_FRAC = 14;
    localparam int SDC_W = 3;
    localparam int SHIFT_W = 3;
    localparam int STAGE_W = 3;
    localparam int BF_W = 8;
    localparam int PROD_W = 36;

    // counter limits and steps
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 10'h3FF;
    localparam logic [BF_W-1:0] BF_LAST = 8'hFF;
    localparam logic [3:0] QSH_TOP = 4'h8;
    localparam logic [3:0] QSH_GRP = 4'h2;
    localparam logic [STAGE_W-1:0] STAGE_ZERO = 3'h0;
    localparam logic [STAGE_W-1:0] STAGE_ONE = 3'h1;
    // passes 1..3 are stages 0..2; pass 4 (radix-16) is stages 3 and 4
    localparam logic [STAGE_W-1:0] PASS4_STAGE = 3'h3;
    localparam logic [STAGE_W-1:0] LAST_STAGE = 3'h4;

    // reset programming: forward transform, no extra shift
    localparam logic CFG_INV_RST = 1'b0;
    localparam logic [SDC_W-1:0] CFG_SDC_RST = 3'h0;

    // per-pass right shift by scale code, {pass4,pass3,pass2,pass1}, 3 bits each
    localparam logic [4*SHIFT_W-1:0] SHIFT_TAB [8] = '{
        12'h249, 12'h24A, 12'h252, 12'h292,
        12'h293, 12'h493, 12'h693, 12'h893
    };

    // twiddle scaling
    localparam real TW_ONE = 16384.0;
    localparam real TWO_PI = 6.283185307179586;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b0_0001,
        ST_LOAD   = 5'b0_0010,
        ST_COMP   = 5'b0_0100,
        ST_READY  = 5'b0_1000,
        ST_UNLOAD = 5'b1_0000
    } ff_state_e;

endpackage

/* File: logic/ff_radix4.sv */
`timescale 1ns/1ps
module ff_radix4 (
    // control
    input wire logic [ff_pkg::SHIFT_W-1:0] shift_i,
    input wire logic inverse_i,
    input wire logic narrow_i,
    // butterfly inputs
    input wire logic [3:0][ff_pkg::INT_W-1:0] x_re_i,
    input wire logic [3:0][ff_pkg::INT_W-1:0] x_im_i,
    // twiddles for legs 1..3
    input wire logic [2:0][ff_pkg::TW_W-1:0] w_re_i,
    input wire logic [2:0][ff_pkg::TW_W-1:0] w_im_i,
    // results
    output logic [3:0][ff_pkg::INT_W-1:0] y_re_o,
    output logic [3:0][ff_pkg::INT_W-1:0] y_im_o,
    output logic ovf_o
);
    import ff_pkg::*;

    localparam logic signed [PROD_W-1:0] RND_HALF = 36'sh0_0000_2000;
    localparam logic signed [PROD_W-1:0] MAX_WIDE = 36'sh0_0000_7FFF;
    localparam logic signed [PROD_W-1:0] MAX_NARROW = 36'sh0_0000_0FFF;

    // round-to-nearest right shift of one input
    function automatic logic signed [PROD_W-1:0] rnd_shr(input logic signed [INT_W-1:0] x,
                                                        input logic [SHIFT_W-1:0] s);
        logic signed [PROD_W-1:0] t;
        t = PROD_W'(x);
        if (s != 3'h0) begin
            t = (t + (36'sh0_0000_0001 <<< (s - 3'h1))) >>> s;
        end
        return t;
    endfunction

    // clamp to the word, flag in top bit
    function automatic logic [INT_W:0] sat(input logic signed [PROD_W-1:0] v,
                                           input logic nar);
        logic signed [PROD_W-1:0] hi;
        hi = nar ? MAX_NARROW : MAX_WIDE;
        if (v > hi) begin
            return {1'b1, hi[INT_W-1:0]};
        end else if (v < -hi - 36'sh0_0000_0001) begin
            return {1'b1, INT_W'(-hi - 36'sh0_0000_0001)};
        end
        return {1'b0, v[INT_W-1:0]};
    endfunction

    logic signed [PROD_W-1:0] a_re [4];
    logic signed [PROD_W-1:0] a_im [4];
    logic signed [PROD_W-1:0] b_re [4];
    logic signed [PROD_W-1:0] b_im [4];
    logic signed [PROD_W-1:0] t_re, t_im, u_re, u_im;
    logic [INT_W:0] s_re [4];
    logic [INT_W:0] s_im [4];

    // scaled inputs, radix-4 decimation-in-frequency sums
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            a_re[k] = rnd_shr(x_re_i[k], shift_i);
            a_im[k] = rnd_shr(x_im_i[k], shift_i);
        end
        t_re = a_re[0] - a_re[2];
        t_im = a_im[0] - a_im[2];
        u_re = a_re[1] - a_re[3];
        u_im = a_im[1] - a_im[3];
        b_re[0] = a_re[0] + a_re[1] + a_re[2] + a_re[3];
        b_im[0] = a_im[0] + a_im[1] + a_im[2] + a_im[3];
        b_re[2] = a_re[0] - a_re[1] + a_re[2] - a_re[3];
        b_im[2] = a_im[0] - a_im[1] + a_im[2] - a_im[3];
        // inverse swaps the -j and +j legs
        b_re[1] = inverse_i ? t_re - u_im : t_re + u_im;
        b_im[1] = inverse_i ? t_im + u_re : t_im - u_re;
        b_re[3] = inverse_i ? t_re + u_im : t_re - u_im;
        b_im[3] = inverse_i ? t_im - u_re : t_im + u_re;
    end

    // leg 0 needs no twiddle
    assign s_re[0] = sat(b_re[0], narrow_i);
    assign s_im[0] = sat(b_im[0], narrow_i);

    // twiddle legs, rounded after the product
    for (genvar k = 1; k < 4; k++) begin : g_leg
        logic signed [PROD_W-1:0] wr, wi, pr, pi;
        assign wr = PROD_W'($signed(w_re_i[k-1]));
        assign wi = PROD_W'($signed(w_im_i[k-1]));
        assign pr = (b_re[k] * wr - b_im[k] * wi + RND_HALF) >>> TW_FRAC;
        assign pi = (b_re[k] * wi + b_im[k] * wr + RND_HALF) >>> TW_FRAC;
        assign s_re[k] = sat(pr, narrow_i);
        assign s_im[k] = sat(pi, narrow_i);
    end

    always_comb begin
        ovf_o = 1'b0;
        for (int k = 0; k < 4; k++) begin
            y_re_o[k] = s_re[k][INT_W-1:0];
            y_im_o[k] = s_im[k][INT_W-1:0];
            ovf_o = ovf_o | s_re[k][INT_W] | s_im[k][INT_W];
        end
    end

endmodule

/* File: logic/ff_engine.sv */
`timescale 1ns/1ps
// Behaviour
// - all storage on rising clock edge
// - programming happens while sync clear held
// - inverse select 0 forward, 1 inverse
// - fixed four bits shift per transform
// - scale code adds its value in shifts
// - reset default: forward, no extra shift
// - program inputs sampled only during clear
// - clear also resets operational state
// - samples are 13-bit two's-complement complex
// - natural order, one sample per cycle
// - results 13-bit, natural order from zero
// - output only when ready and enabled
// - radix-4 DIF butterflies with twiddles
// - four passes, last effectively radix-16
// - passes read, compute, write dual-port memory; code reads and writes four words a cycle
// - round-to-nearest on twiddle products, shifts
// - per-pass shift table by scale code
// - eleven total shift bits never overflow
// - saturate and flag overflow, clear at start
// - block start marks sample zero
// - first result two cycles after enable
module ff_engine (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // programming
    input wire logic sync_clear_program_i,
    input wire logic inverse_select_i,
    input wire logic [ff_pkg::SDC_W-1:0] scale_down_code_i,
    // sample input
    input wire logic in_block_start_i,
    input wire logic [ff_pkg::IN_W-1:0] in_real_i,
    input wire logic [ff_pkg::IN_W-1:0] in_imag_i,
    // result control
    input wire logic out_enable_i,
    // status
    output logic load_active_o,
    output logic busy_o,
    output logic done_o,
    output logic overflow_flag_o,
    output logic inverse_active_o,
    output logic [ff_pkg::SDC_W-1:0] scale_code_active_o,
    // result
    output logic out_valid_o,
    output logic out_block_start_o,
    output logic [ff_pkg::IN_W-1:0] out_real_o,
    output logic [ff_pkg::IN_W-1:0] out_imag_o
);
    import ff_pkg::*;

    // base-4 digit reversal turns the in-place DIF order back to natural order
    function automatic logic [ADDR_W-1:0] digit_rev(input logic [ADDR_W-1:0] a);
        return {a[1:0], a[3:2], a[5:4], a[7:6], a[9:8]};
    endfunction

    ff_state_e state_q, state_d;
    logic [ADDR_W-1:0] cnt_q, cnt_d;
    logic [STAGE_W-1:0] stage_q, stage_d;
    logic inv_q;
    logic [SDC_W-1:0] sdc_q;
    logic ovf_q;
    logic busy_q, load_q, done_q;
    logic [2*INT_W-1:0] mem_q [N_PTS];
    logic signed [TW_W-1:0] tw_cos [N_PTS];
    logic signed [TW_W-1:0] tw_sin [N_PTS];
    logic [2*INT_W-1:0] rd_q;
    logic rd_vld_q, rd_first_q;
    logic out_valid_q, out_first_q;
    logic [IN_W-1:0] out_re_q, out_im_q;

    logic clear, start_ok, last_cnt, last_bf, bf_ovf;
    logic [4*SHIFT_W-1:0] shift_row;
    logic [SHIFT_W-1:0] p4_shift, stage_shift;
    logic [3:0] qsh;
    logic [ADDR_W-1:0] qlen, jm, base;
    logic [3:0][ADDR_W-1:0] bf_addr;
    logic [2:0][ADDR_W-1:0] tw_e;
    logic [3:0][INT_W-1:0] x_re, x_im, y_re, y_im;
    logic [2:0][TW_W-1:0] w_re, w_im;

    assign clear = sync_clear_program_i;
    assign last_cnt = (cnt_q == ADDR_LAST);
    assign last_bf = (cnt_q[BF_W-1:0] == BF_LAST);
    // a new block is refused while loading or computing
    assign start_ok = in_block_start_i & ~clear
                      & ((state_q == ST_IDLE) | (state_q == ST_READY));

    // quarter-wave would be smaller; full table keeps indexing trivial
    initial begin
        for (int i = 0; i < N_PTS; i++) begin
            tw_cos[i] = TW_W'($rtoi($floor(TW_ONE * $cos(TWO_PI * i / N_PTS) + 0.5)));
            tw_sin[i] = TW_W'($rtoi($floor(TW_ONE * $sin(TWO_PI * i / N_PTS) + 0.5)));
        end
    end

    // programming capture, held until the next clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inv_q <= CFG_INV_RST;
            sdc_q <= CFG_SDC_RST;
        end else if (clear) begin
            inv_q <= inverse_select_i;
            sdc_q <= scale_down_code_i;
        end
    end

    // shift of the current stage; pass 4 is split over its two radix-4 stages
    assign shift_row = SHIFT_TAB[sdc_q];
    assign p4_shift = shift_row[SHIFT_W*3 +: SHIFT_W];
    always_comb begin
        if (stage_q < PASS4_STAGE) begin
            stage_shift = shift_row[SHIFT_W*stage_q +: SHIFT_W];
        end else if (stage_q == PASS4_STAGE) begin
            stage_shift = (p4_shift + 3'h1) >> 1;
        end else begin
            stage_shift = p4_shift >> 1;
        end
    end

    // in-place addressing of the radix-4 butterfly in this stage
    always_comb begin
        qsh = QSH_TOP - {stage_q, 1'b0};
        qlen = ADDR_ONE << qsh;
        jm = {2'b00, cnt_q[BF_W-1:0]} & (qlen - ADDR_ONE);
        base = (({2'b00, cnt_q[BF_W-1:0]} >> qsh) << (qsh + QSH_GRP)) | jm;
        bf_addr[0] = base;
        bf_addr[1] = base + qlen;
        bf_addr[2] = base + (qlen << 1);
        bf_addr[3] = base + (qlen << 1) + qlen;
        tw_e[0] = jm << {stage_q, 1'b0};
        tw_e[1] = tw_e[0] << 1;
        tw_e[2] = (tw_e[0] << 1) + tw_e[0]; // stays below the block size, at most 3 * 255 = 765, so it never wraps
    end

    // operands from memory; forward twiddle is the conjugate phasor
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            x_re[k] = mem_q[bf_addr[k]][2*INT_W-1:INT_W];
            x_im[k] = mem_q[bf_addr[k]][INT_W-1:0];
        end
        for (int k = 0; k < 3; k++) begin
            w_re[k] = tw_cos[tw_e[k]];
            w_im[k] = inv_q ? tw_sin[tw_e[k]] : -tw_sin[tw_e[k]];
        end
    end

    ff_radix4 u_bfly (
        .shift_i(stage_shift),
        .inverse_i(inv_q),
        .narrow_i(stage_q == LAST_STAGE),
        .x_re_i(x_re),
        .x_im_i(x_im),
        .w_re_i(w_re),
        .w_im_i(w_im),
        .y_re_o(y_re),
        .y_im_o(y_im),
        .ovf_o(bf_ovf)
    );

    // sample memory: one write while loading, four in place while computing
    always_ff @(posedge clk_i) begin
        if (!clear && (start_ok || state_q == ST_LOAD)) begin
            mem_q[cnt_q] <= {{(INT_W-IN_W){in_real_i[IN_W-1]}}, in_real_i,
                             {(INT_W-IN_W){in_imag_i[IN_W-1]}}, in_imag_i};
        end else if (!clear && state_q == ST_COMP) begin
            for (int k = 0; k < 4; k++) begin
                mem_q[bf_addr[k]] <= {y_re[k], y_im[k]};
            end
        end
    end

    // sequencing of load, five radix-4 stages, and result burst
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        stage_d = stage_q;
        if (clear) begin
            state_d = ST_IDLE;
            cnt_d = ADDR_ZERO;
            stage_d = STAGE_ZERO;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_READY: begin
                    if (start_ok) begin
                        state_d = ST_LOAD;
                        cnt_d = cnt_q + ADDR_ONE;
                    end else if (state_q == ST_READY && out_enable_i) begin
                        state_d = ST_UNLOAD;
                    end
                end
                ST_LOAD: begin
                    cnt_d = cnt_q + ADDR_ONE;
                    if (last_cnt) begin
                        state_d = ST_COMP;
                        stage_d = STAGE_ZERO;
                    end
                end
                ST_COMP: begin
                    cnt_d = cnt_q + ADDR_ONE;
                    if (last_bf) begin
                        cnt_d = ADDR_ZERO;
                        if (stage_q == LAST_STAGE) begin
                            state_d = ST_READY;
                            stage_d = STAGE_ZERO;
                        end else begin
                            stage_d = stage_q + STAGE_ONE;
                        end
                    end
                end
                ST_UNLOAD: begin
                    cnt_d = cnt_q + ADDR_ONE; // wraps to zero after the last bin
                    if (last_cnt) begin
                        state_d = ST_READY; // result stays downloadable again
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    cnt_d = ADDR_ZERO;
                    stage_d = STAGE_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
            cnt_q <= ADDR_ZERO;
            stage_q <= STAGE_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            stage_q <= stage_d;
        end
    end

    // status flags registered from the next state so they track it exactly
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            load_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            load_q <= (state_d == ST_LOAD);
            busy_q <= (state_d == ST_LOAD) | (state_d == ST_COMP);
            done_q <= (state_d == ST_READY);
        end
    end

    // sticky overflow; start and set never coincide, compute is not loading
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ovf_q <= 1'b0;
        end else if (clear || start_ok) begin
            ovf_q <= 1'b0;
        end else if (state_q == ST_COMP && bf_ovf) begin
            ovf_q <= 1'b1;
        end
    end

    // first read stage, launched from the next state or the burst lands a cycle late
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_vld_q <= 1'b0;
            rd_first_q <= 1'b0;
        end else begin
            rd_vld_q <= ~clear & (state_d == ST_UNLOAD);
            rd_first_q <= ~clear & (state_d == ST_UNLOAD) & (cnt_d == ADDR_ZERO);
        end
    end

    // memory read kept without reset so it can map onto a ram port
    always_ff @(posedge clk_i) begin
        rd_q <= mem_q[digit_rev(cnt_d)];
    end

    // output stage, two edges after the enable was taken
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_valid_q <= 1'b0;
            out_first_q <= 1'b0;
            out_re_q <= '0;
            out_im_q <= '0;
        end else begin
            out_valid_q <= ~clear & rd_vld_q;
            out_first_q <= ~clear & rd_first_q;
            if (rd_vld_q) begin
                out_re_q <= rd_q[INT_W +: IN_W]; // last stage already clamped to 13 bits
                out_im_q <= rd_q[0 +: IN_W];
            end
        end
    end

    assign load_active_o = load_q;
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign overflow_flag_o = ovf_q;
    assign inverse_active_o = inv_q;
    assign scale_code_active_o = sdc_q;
    assign out_valid_o = out_valid_q;
    assign out_block_start_o = out_first_q;
    assign out_real_o = out_re_q;
    assign out_imag_o = out_im_q;

endmodule

/* File: dv/ff_engine_checker.sv */
`timescale 1ns/1ps
module ff_engine_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // engine inputs
    input wire logic sync_clear_program_i,
    input wire logic inverse_select_i,
    input wire logic [ff_pkg::SDC_W-1:0] scale_down_code_i,
    input wire logic in_block_start_i,
    input wire logic out_enable_i,
    // engine outputs
    input wire logic load_active_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic overflow_flag_o,
    input wire logic inverse_active_o,
    input wire logic [ff_pkg::SDC_W-1:0] scale_code_active_o,
    input wire logic out_valid_o,
    input wire logic out_block_start_o
);
    import ff_pkg::*;
    localparam logic [10:0] LOAD_CYC = 11'h3FF;
    localparam logic [10:0] COMP_CYC = 11'h500;
    localparam logic [10:0] BURST_CYC = 11'h400;
    logic clr;
    logic go;
    logic [10:0] ld_q;
    logic [10:0] cp_q;
    logic [10:0] ov_q;
    logic dl_q;
    // a download request that no clear or block start overrides
    assign clr = sync_clear_program_i;
    assign go = done_o && out_enable_i && !clr && !in_block_start_i;
    // run lengths, so long windows need no long repetition
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ld_q <= '0;
            cp_q <= '0;
            ov_q <= '0;
            dl_q <= 1'b0;
        end else begin
            // download in flight: busy is low but a block start is refused
            dl_q <= clr ? 1'b0 : (go ? 1'b1 : (done_o ? 1'b0 : dl_q));
            ld_q <= load_active_o ? ld_q + 1'b1 : '0;
            cp_q <= (busy_o && !load_active_o) ? cp_q + 1'b1 : '0;
            ov_q <= out_valid_o ? ov_q + 1'b1 : '0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_PROG_TAKE: assert property (
        clr |=> inverse_active_o == $past(inverse_select_i)
            && scale_code_active_o == $past(scale_down_code_i)) else $error("program not taken");
    AST_PROG_HOLD: assert property (
        !clr |=> $stable({inverse_active_o, scale_code_active_o})) else $error("program changed");
    AST_CLEAR_STATE: assert property (
        clr |=> !(busy_o || done_o || load_active_o || out_valid_o || overflow_flag_o))
        else $error("clear left state active");
    AST_LOAD_TAKE: assert property (
        in_block_start_i && !clr && !busy_o && (done_o || !dl_q)
        |=> load_active_o && busy_o && !overflow_flag_o)
        else $error("block start not taken");
    AST_LOAD_LEN: assert property (
        $fell(load_active_o) && !$past(clr) |-> ld_q == LOAD_CYC) else $error("load length");
    AST_COMP_LEN: assert property (
        $rose(done_o) && $past(busy_o) |-> cp_q == COMP_CYC) else $error("compute length");
    AST_DONE_DROP: assert property (go |=> !done_o) else $error("done kept");
    AST_OUT_START: assert property (
        go ##1 (!clr && !in_block_start_i) |=> out_valid_o && out_block_start_o)
        else $error("burst not started two cycles after enable");
    AST_OUT_CAUSE: assert property (
        $rose(out_valid_o) |-> $past(done_o, 2) && $past(out_enable_i, 2))
        else $error("burst without done and enable");
    AST_BURST_LEN: assert property (
        $fell(out_valid_o) && !$past(clr) |-> ov_q == BURST_CYC) else $error("burst length");
    AST_OVF_HOLD: assert property (
        overflow_flag_o && !clr && !(in_block_start_i && !busy_o) |=> overflow_flag_o)
        else $error("overflow flag dropped");
    cover property ($rose(done_o));
    cover property (go);
    cover property (clr && busy_o);
    cover property ($rose(overflow_flag_o));
endmodule
bind ff_engine ff_engine_checker ff_engine_checker_i (
    .clk_i, .rstn_i, .sync_clear_program_i, .inverse_select_i, .scale_down_code_i,
    .in_block_start_i, .out_enable_i, .load_active_o, .busy_o, .done_o, .overflow_flag_o,
    .inverse_active_o, .scale_code_active_o, .out_valid_o, .out_block_start_o
);

/* File: dv/ff_stream_model.sv */
`timescale 1ns/1ps
module ff_stream_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // block request
    input wire logic go_i,
    input wire logic dc_i,
    input wire logic [ff_pkg::ADDR_W-1:0] pos_i,
    input wire logic [ff_pkg::IN_W-1:0] amp_i,
    // sample stream
    output logic in_block_start_o,
    output logic [ff_pkg::IN_W-1:0] in_real_o,
    output logic [ff_pkg::IN_W-1:0] in_imag_o
);
    import ff_pkg::*;
    logic [ADDR_W:0] n_q;
    logic [ADDR_W:0] n;
    logic hit;
    // falling-edge source; once started a block runs to its end unless rstn_i falls
    always @(negedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            n_q <= 11'h400;
            in_block_start_o <= 1'b0;
            in_real_o <= '0;
            in_imag_o <= '0;
        end else if (n_q != 11'h400 || go_i) begin
            n = (n_q == 11'h400) ? 11'h000 : n_q;
            hit = dc_i || n[ADDR_W-1:0] == pos_i;
            in_block_start_o <= (n == 11'h000);
            in_real_o <= hit ? amp_i : '0;
            in_imag_o <= hit ? amp_i : '0;
            n_q <= n + 1'b1;
        end else begin
            // idle lines toggle so stale data never looks valid
            in_block_start_o <= 1'b0;
            in_real_o <= ~in_real_o;
            in_imag_o <= ~in_imag_o;
        end
    end
endmodule

/* File: dv/ff_engine_tb.sv */
`timescale 1ns/1ps
module ff_engine_tb;
    import ff_pkg::*;
    typedef struct packed {
        logic inv;
        logic [SDC_W-1:0] code;
        logic dc;
        logic [ADDR_W-1:0] pos;
        logic [IN_W-1:0] amp;
        logic ovf;
    } ff_row_s;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic clr = 1'b0;
    logic inv = 1'b0;
    logic en = 1'b0;
    logic go = 1'b0;
    logic dc = 1'b0;
    logic [SDC_W-1:0] code = '0;
    logic [ADDR_W-1:0] pos = '0;
    logic [IN_W-1:0] amp = '0;
    logic bs, ld, busy, done, ovf, inv_a, ov, obs;
    logic [SDC_W-1:0] code_a;
    logic [IN_W-1:0] xr, xi, yr, yi;
    int miscompares = 0;
    int compares = 0;
    ff_row_s rows [11];
    // 125 MHz
    always #4 clk_i = ~clk_i;
    ff_stream_model ff_stream_model_i (
        .clk_i, .rstn_i, .go_i(go), .dc_i(dc), .pos_i(pos), .amp_i(amp),
        .in_block_start_o(bs), .in_real_o(xr), .in_imag_o(xi)
    );
    ff_engine ff_engine_i (
        .clk_i, .rstn_i, .sync_clear_program_i(clr), .inverse_select_i(inv),
        .scale_down_code_i(code), .in_block_start_i(bs), .in_real_i(xr), .in_imag_i(xi),
        .out_enable_i(en), .load_active_o(ld), .busy_o(busy), .done_o(done),
        .overflow_flag_o(ovf), .inverse_active_o(inv_a), .scale_code_active_o(code_a),
        .out_valid_o(ov), .out_block_start_o(obs), .out_real_o(yr), .out_imag_o(yi)
    );
    task automatic tally_and_finish();
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [IN_W-1:0] seen,
                         input logic [IN_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic flag(input int sel);
        return sel == 0 ? ld : obs;
    endfunction
    // bounded poll on falling edges; running out ends the run
    task automatic wait_for(input int sel, input int lim);
        int i;
        i = 0;
        while (flag(sel) !== 1'b1) begin
            @(negedge clk_i);
            i++;
            if (i > lim) begin
                miscompares++;
                tally_and_finish();
            end
        end
    endtask
    // an impulse at 10'h100 rotates by a quarter turn per bin; constants land in bin 0
    function automatic logic [2*IN_W-1:0] expect_bin(input ff_row_s r, input int k);
        int a;
        int q;
        logic [IN_W-1:0] p;
        logic [IN_W-1:0] m;
        a = r.dc ? (k == 0 ? $signed(r.amp) * N_PTS : 0) : $signed(r.amp);
        a = a >>> (4 + r.code);
        a = a > 4095 ? 4095 : (a < -4096 ? -4096 : a);
        q = r.pos == 10'h100 ? k % 4 : 0;
        q = r.inv ? (4 - q) % 4 : q;
        p = IN_W'(a);
        m = IN_W'(-a);
        return {((q < 2) ? p : m), ((q == 0 || q == 3) ? p : m)};
    endfunction
    // values changed after the clear edge must be ignored
    task automatic prog_cfg(input logic i, input logic [SDC_W-1:0] c);
        @(negedge clk_i);
        clr = 1'b1;
        inv = i;
        code = c;
        @(negedge clk_i);
        clr = 1'b0;
        inv = ~i;
        code = ~c;
        check("inverse_active", inv_a, i);
        check("scale_code", code_a, c);
        check("busy", busy, 1'b0);
        @(negedge clk_i);
        check("inverse_active", inv_a, i);
        check("scale_code", code_a, c);
    endtask
    task automatic start_block(input ff_row_s r);
        dc <= r.dc;
        pos <= r.pos;
        amp <= r.amp;
        go <= 1'b1;
        @(negedge clk_i);
        go <= 1'b0;
        wait_for(0, 4);
        check("overflow_flag", ovf, 1'b0);
    endtask
    // enable is raised while busy, so an early burst would be caught
    task automatic download(input ff_row_s r);
        logic [2*IN_W-1:0] e;
        en = 1'b1;
        wait_for(1, 4000);
        en = 1'b0;
        for (int k = 0; k < N_PTS; k++) begin
            e = expect_bin(r, k);
            if (!r.ovf || k == 0) begin
                check("out_real", yr, e[2*IN_W-1:IN_W]);
                check("out_imag", yi, e[IN_W-1:0]);
            end
            check("out_valid", ov, 1'b1);
            check("out_block_start", obs, k == 0);
            @(negedge clk_i);
        end
        check("out_valid", ov, 1'b0);
        check("overflow_flag", ovf, r.ovf);
        check("done", done, 1'b1);
    endtask
    initial begin
        for (int i = 0; i < 8; i++) begin
            rows[i + 1] = '{i[0], 3'(i), 1'b0, 10'h100, 13'h0800, 1'b0};
        end
        rows[0] = '{1'b0, 3'h0, 1'b1, 10'h000, 13'h0FFF, 1'b1};
        rows[9] = '{1'b0, 3'h3, 1'b0, 10'h000, 13'h1800, 1'b0};
        rows[10] = '{1'b0, 3'h7, 1'b1, 10'h000, 13'h1000, 1'b0};
        repeat (5) @(negedge clk_i);
        rstn_i = 1'b1;
        check("inverse_active", inv_a, 1'b0);
        check("scale_code", code_a, 3'h0);
        foreach (rows[i]) begin
            prog_cfg(rows[i].inv, rows[i].code);
            start_block(rows[i]);
            download(rows[i]);
        end
        // the same result downloads a second time
        download(rows[10]);
        // clear in mid-computation drops the block
        start_block(rows[1]);
        repeat (1100) @(negedge clk_i);
        prog_cfg(1'b1, 3'h2);
        repeat (1400) @(negedge clk_i);
        check("done", done, 1'b0);
        // reset in mid-load brings back forward mode with no extra shift
        start_block(rows[1]);
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b0;
        @(negedge clk_i);
        check("inverse_active", inv_a, 1'b0);
        check("scale_code", code_a, 3'h0);
        check("load_active", ld, 1'b0);
        rstn_i = 1'b1;
        @(negedge clk_i);
        start_block(rows[1]);
        download(rows[1]);
        tally_and_finish();
    end
endmodule
